// ---- dv/iwdit_host_model.sv ----
// Host CPU and firmware model: I/O cycles and the oscillator (502 ns period by default)
module iwdit_host_model
  import iwdit_pkg::*;
#(
  parameter logic [15:0] INDEX_PORT  = IWDIT_INDEX_PORT_DEF, // Index port
  parameter int          OSC_HALF_NS = 251                   // Oscillator half period
)(
  input  wire logic       clk,       // System clock
  input  wire logic [7:0] io_rdata,  // Read data
  input  wire logic       io_rvalid, // Read data valid
  output iwdit_io_t       io,        // I/O cycle
  output logic            rtc_osc    // Oscillator
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus and oscillator at time zero
  initial begin
    io      = '0;
    rtc_osc = 1'b0;
  end

  // Free-running oscillator, own time base
  always #(OSC_HALF_NS) rtc_osc = ~rtc_osc;

  ////////////////////////////////////////////////////////////////////////////
  // One write cycle; bus scrambled after release
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io.addr  <= a;
    io.wdata <= d;
    io.wr    <= 1'b1;
    @(posedge clk);
    io.wr    <= 1'b0;
    io.addr  <= ~a;
    io.wdata <= ~d;
  endtask

  // One read cycle, answer taken while valid
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    io.addr <= a;
    io.rd   <= 1'b1;
    @(posedge clk);
    io.rd   <= 1'b0;
    io.addr <= ~a;
    @(negedge clk);
    d = io_rdata;
    v = io_rvalid;
  endtask

  // Indexed register access
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io_wr(INDEX_PORT, idx);
    io_wr(IWDIT_DATA_PORT, d);
  endtask

  task automatic rreg(input logic [7:0] idx, output logic [7:0] d, output logic v);
    io_wr(INDEX_PORT, idx);
    io_rd(IWDIT_DATA_PORT, d, v);
  endtask
endmodule

// ---- dv/iwdit_top_asserts.sv ----
// Port-level checks of the window decode and idle timer block
module iwdit_top_asserts
  import iwdit_pkg::*;
#(
  parameter logic [15:0] INDEX_PORT = IWDIT_INDEX_PORT_DEF // Index port
)(
  input wire logic                     clk,                     // System clock
  input wire logic                     rstn,                    // Reset, active low
  input wire iwdit_io_t                io,                      // I/O cycle
  input wire logic                     ten_bit_decode_select,   // Ten-bit decode
  input wire logic [7:0]               io_rdata,                // Read data
  input wire logic                     io_rvalid,               // Read data valid
  input wire logic                     system_mgmt_interrupt_n, // Interrupt, active low
  input wire logic [IWDIT_NUM_TMR-1:0] timeout_status,          // Sticky flags
  input wire logic [IWDIT_NUM_TMR-1:0] timer_enabled            // Timers counting
);
  logic port_rd, data_rd, data_wr, idx_wr, idx_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded port cycles
  assign data_rd = io.rd && io.addr == IWDIT_DATA_PORT;
  assign data_wr = io.wr && io.addr == IWDIT_DATA_PORT;
  assign idx_wr  = io.wr && io.addr == INDEX_PORT;
  assign idx_rd  = io.rd && io.addr == INDEX_PORT;
  assign port_rd = data_rd || idx_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // Register port answers and interrupt level
  chk_read_answer: assert property (port_rd |=> io_rvalid)
    else $error("read not answered");
  chk_idle_answer: assert property (!port_rd |=> !io_rvalid)
    else $error("valid without a read");
  chk_rdata_hold: assert property (!io_rvalid |-> $stable(io_rdata))
    else $error("read data moved");
  chk_index_echo: assert property (idx_wr ##2 idx_rd |=> io_rdata == $past(io.wdata, 3)) // Index
    else $error("index echo wrong");
  chk_smi_level: assert property (system_mgmt_interrupt_n == (timeout_status == '0))
    else $error("interrupt disagrees with status");

  // Per-timer start, timeout and clear
  for (genvar i = 0; i < IWDIT_NUM_TMR; i++) begin : g_tmr
    chk_timeout_stops: assert property ($rose(timeout_status[i]) |-> $fell(timer_enabled[i]))
      else $error("timeout left timer enabled");
    chk_start_cause: assert property ($rose(timer_enabled[i]) |-> $past(data_wr, 2))
      else $error("timer started without a write");
    chk_status_clear: assert property ($fell(timeout_status[i]) |-> $past(data_rd, 2))
      else $error("status cleared without a read");
  end

  // Main scenarios reached
  cover property ($rose(timeout_status[1]));
  cover property ($fell(timeout_status[1]));
  cover property (idx_wr ##2 idx_rd);
endmodule

bind iwdit_top iwdit_top_asserts #(.INDEX_PORT(INDEX_PORT)) i_iwdit_top_asserts (
  .clk(clk), .rstn(rstn), .io(io), .ten_bit_decode_select(ten_bit_decode_select),
  .io_rdata(io_rdata), .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
  .io_rvalid(io_rvalid), .timeout_status(timeout_status), .timer_enabled(timer_enabled)
);

// ---- dv/testbench.sv ----
// Self-checking bench of the window decode and idle timers
module testbench
  import iwdit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int OSC_HALF = 251;
  localparam int FINE_CYC = 4 * 2 * OSC_HALF / 25 + 1;  // Clocks per fine step
  localparam int CRS_CYC  = 16 * 2 * OSC_HALF / 25 + 1; // Clocks per coarse step

  logic                     clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     ten_bit_decode_select = 1'b0;
  iwdit_io_t                io;
  logic                     rtc_osc;
  logic [7:0]               io_rdata;
  logic                     io_rvalid;
  logic                     system_mgmt_interrupt_n;
  logic [IWDIT_NUM_TMR-1:0] timeout_status;
  logic [IWDIT_NUM_TMR-1:0] timer_enabled;
  int                       fails = 0;
  int                       n_compared = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  iwdit_host_model #(.OSC_HALF_NS(OSC_HALF)) i_iwdit_host_model (
    .clk(clk), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io(io), .rtc_osc(rtc_osc)
  );

  iwdit_top #(.FINE_TICKS(4), .COARSE_TICKS(16)) i_iwdit_top (
    .clk(clk), .rstn(rstn), .io(io), .rtc_osc(rtc_osc),
    .ten_bit_decode_select(ten_bit_decode_select), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
    .timeout_status(timeout_status), .timer_enabled(timer_enabled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and window reference
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic whit(input logic [15:0] a, input logic [7:0] hi, lo,
                                input logic ten);
    logic [15:0] care;
    care = {{6{~ten}}, 5'h1F, lo[1:0] != 2'h3, lo[1:0] < 2'h2, lo[1:0] == 2'h0, 2'h0};
    return ((a ^ {hi, lo[7:2], 2'h0}) & care) == 16'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, field access, unmapped index, index echo
  task automatic t_reset;
    logic [7:0] d;
    logic       v;
    cmp({2'h0, timer_enabled, system_mgmt_interrupt_n}, 8'h01);
    for (int k = 8'h84; k <= 8'h8E; k++) begin
      i_iwdit_host_model.rreg(8'(k), d, v);
      cmp(d, (k >= 8'h8A) ? 8'h0F : 8'h00);
    end
    i_iwdit_host_model.wreg(8'h88, 8'hFF);
    i_iwdit_host_model.rreg(8'h88, d, v);
    cmp(d, 8'h00);
    i_iwdit_host_model.wreg(IWDIT_IDX_TMR0, 8'h7F);
    i_iwdit_host_model.rreg(IWDIT_IDX_TMR0, d, v);
    cmp(d, 8'h3F);
    i_iwdit_host_model.wreg(8'h8B, 8'h7F);
    i_iwdit_host_model.rreg(8'h8B, d, v);
    cmp(d, 8'h2F);
    i_iwdit_host_model.wreg(IWDIT_IDX_TMR0, 8'h0F);
    i_iwdit_host_model.io_wr(IWDIT_INDEX_PORT_DEF, 8'h8C);
    i_iwdit_host_model.io_rd(IWDIT_INDEX_PORT_DEF, d, v);
    cmp(d, 8'h8C);
    cmp({7'h0, v}, 8'h01);
  endtask

  // Countdown to timeout, then read clear
  task automatic t_timeout(input int t, input logic [7:0] val, input int lo, input int hi);
    logic [7:0] d;
    logic [7:0] idx;
    logic       v;
    int         n;
    idx = IWDIT_IDX_TMR0 + 8'(t);
    n = 0;
    i_iwdit_host_model.wreg(idx, val);
    while (timeout_status[t] !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    cmp(8'(n >= lo && n < hi), 8'h01);
    cmp({6'h0, timer_enabled[t], system_mgmt_interrupt_n}, 8'h00);
    i_iwdit_host_model.rreg(idx, d, v);
    cmp(d, {2'h1, val[5:0]});
    repeat (2) @(negedge clk);
    cmp({6'h0, timeout_status[t], system_mgmt_interrupt_n}, 8'h01);
    i_iwdit_host_model.wreg(idx, val & 8'h7F);
  endtask

  // Touch one address; timer lives only if it retriggers
  task automatic probe(input int t, input logic [15:0] a, input logic hit, input logic ex);
    logic [7:0] d;
    logic [7:0] idx;
    logic       v;
    idx = IWDIT_IDX_TMR0 + 8'(t);
    i_iwdit_host_model.wreg(idx, {3'h5, ex, 4'h2});
    for (int k = 0; k < 10; k++) begin
      repeat (36) @(posedge clk);
      if (k[0]) i_iwdit_host_model.io_rd(a, d, v);
      else i_iwdit_host_model.io_wr(a, 8'h5A);
    end
    i_iwdit_host_model.rreg(idx, d, v);
    cmp(d, {hit, ~hit, 1'b1, ex, 4'h2});
    i_iwdit_host_model.wreg(idx, {3'h1, ex, 4'h2});
  endtask

  // Fixed peripheral ranges
  task automatic t_ranges;
    probe(0, 16'h03F8, 1'b1, 1'b0);
    probe(0, 16'h02FF, 1'b1, 1'b0);
    probe(0, 16'h037A, 1'b1, 1'b0);
    probe(0, 16'h037B, 1'b0, 1'b0);
    probe(0, 16'h02F8, 1'b0, 1'b1);
    probe(0, 16'h0378, 1'b1, 1'b1);
    probe(1, 16'h03F5, 1'b1, 1'b0);
    probe(1, 16'h03F6, 1'b0, 1'b0);
    probe(2, 16'h03F6, 1'b1, 1'b0);
    probe(2, 16'h01F8, 1'b0, 1'b0);
  endtask

  // Windows over all size codes and both decode widths
  task automatic t_windows;
    logic [15:0] a;
    i_iwdit_host_model.wreg(IWDIT_IDX_WIN1_HI, 8'h05);
    for (int s = 0; s < 4; s++) begin
      i_iwdit_host_model.wreg(IWDIT_IDX_WIN1_LO, 8'hA0 | 8'(s));
      for (int e = 0; e < 2; e++) begin
        a = 16'h05A0 + 16'((4 << s) - 1 + e);
        probe(3, a, whit(a, 8'h05, 8'hA0 | 8'(s), 1'b0), 1'b0);
      end
    end
    probe(3, 16'h0580, whit(16'h0580, 8'h05, 8'hA3, 1'b0), 1'b0);
    probe(3, 16'h01A0, whit(16'h01A0, 8'h05, 8'hA3, 1'b0), 1'b0);
    @(posedge clk) ten_bit_decode_select <= 1'b1;
    probe(3, 16'h01A0, whit(16'h01A0, 8'h05, 8'hA3, 1'b1), 1'b0);
    probe(3, 16'h04A0, whit(16'h04A0, 8'h05, 8'hA3, 1'b1), 1'b0);
    @(posedge clk) ten_bit_decode_select <= 1'b0;
    i_iwdit_host_model.wreg(IWDIT_IDX_WIN2_HI, 8'h02);
    i_iwdit_host_model.wreg(IWDIT_IDX_WIN2_LO, 8'h41);
    probe(4, 16'h0247, whit(16'h0247, 8'h02, 8'h41, 1'b0), 1'b0);
    probe(4, 16'h0248, whit(16'h0248, 8'h02, 8'h41, 1'b0), 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_timeout(1, 8'hA3, 2 * (FINE_CYC - 1), 3 * FINE_CYC + 12);
    t_timeout(1, 8'hA3, 2 * (FINE_CYC - 1), 3 * FINE_CYC + 12);
    t_timeout(2, 8'h82, CRS_CYC - 1, 2 * CRS_CYC + 12);
    t_timeout(3, 8'hA0, 0, FINE_CYC + 12);
    t_ranges;
    t_windows;
    close_out;
  end

  // Watchdog against a hang
  initial begin
    #1500000;
    fails++;
    close_out;
  end
endmodule

// ---- src/iwdit_idle_timer.sv ----
// One inactivity timer: control register, down counter and timeout
module iwdit_idle_timer
  import iwdit_pkg::*;
#(
  parameter bit HAS_EXCL = 1'b0                  // Bit 4 is the exclusion bit
)(
  input  wire logic           clk,               // System clock
  input  wire logic           rstn,              // Synchronous reset, active low
  input  wire iwdit_tmr_acc_t acc,               // Register access to this timer
  input  wire logic           retrig,            // Qualifying I/O access
  input  wire logic           step_fine,         // Fine step pulse
  input  wire logic           step_coarse,       // Coarse step pulse
  output logic [7:0]          reg_value,         // Register read value
  output logic                excl,              // Second serial exclusion
  output logic                timeout            // One-cycle timeout pulse
);

  typedef enum logic [1:0] {
    IWDIT_TS_OFF = 2'b01,
    IWDIT_TS_RUN = 2'b10
  } iwdit_tstate_t;

  iwdit_tstate_t          state, next_state;
  logic [IWDIT_CNT_W-1:0] max_count, next_max_count;
  logic [IWDIT_CNT_W-1:0] cnt, next_cnt;
  logic                   fine, next_fine;
  logic                   status, next_status;
  logic                   next_excl;
  logic                   next_timeout;
  logic                   step;

  // Next state of the timer
  always_comb begin
    next_state     = state;
    next_max_count = max_count;
    next_cnt       = cnt;
    next_fine      = fine;
    next_status    = status;
    next_excl      = excl;
    next_timeout   = 1'b0;
    step           = fine ? step_fine : step_coarse;
    if (acc.rd) begin
      next_status = 1'b0;
    end
    case (state)
      IWDIT_TS_RUN: begin
        if (retrig) begin
          next_cnt = max_count;
        end else if (step) begin
          if (cnt <= 4'h1) begin
            next_timeout = 1'b1;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
      end
      default: begin
        next_cnt = cnt;
      end
    endcase
    if (acc.wr) begin
      next_max_count = acc.data[IWDIT_CNT_W-1:0];
      next_fine      = acc.data[IWDIT_TB_FINE];
      next_excl      = HAS_EXCL ? acc.data[IWDIT_TB_EXCL] : 1'b0;
      if (!acc.data[IWDIT_TB_ENABLE]) begin
        next_state = IWDIT_TS_OFF;
      end else if (state == IWDIT_TS_OFF) begin
        next_state = IWDIT_TS_RUN;
        next_cnt   = acc.data[IWDIT_CNT_W-1:0];
      end
    end
    if (next_timeout) begin
      next_status = 1'b1;
      next_state  = IWDIT_TS_OFF;
    end
  end

  // Timer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state     <= IWDIT_TS_OFF;
      max_count <= IWDIT_CNT_RESET;
      cnt       <= IWDIT_CNT_RESET;
      fine      <= 1'b0;
      status    <= 1'b0;
      excl      <= 1'b0;
      timeout   <= 1'b0;
    end else begin
      state     <= next_state;
      max_count <= next_max_count;
      cnt       <= next_cnt;
      fine      <= next_fine;
      status    <= next_status;
      excl      <= next_excl;
      timeout   <= next_timeout;
    end
  end

  // Live count is never shown
  assign reg_value = {state == IWDIT_TS_RUN, status, fine, excl, max_count};

endmodule

// ---- src/iwdit_pkg.sv ----
// Constants, field layouts and carrier types of the I/O window decode and idle timers
package iwdit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration ports (index written at the index port, data at EDh)
  localparam logic [15:0] IWDIT_DATA_PORT      = 16'h00ED;
  localparam logic [15:0] IWDIT_INDEX_PORT_DEF = 16'h00EC;

  // Register indices
  localparam logic [7:0] IWDIT_IDX_WIN2_HI = 8'h84;
  localparam logic [7:0] IWDIT_IDX_WIN2_LO = 8'h85;
  localparam logic [7:0] IWDIT_IDX_WIN1_HI = 8'h86;
  localparam logic [7:0] IWDIT_IDX_WIN1_LO = 8'h87;
  localparam logic [7:0] IWDIT_IDX_TMR0    = 8'h8A;
  localparam logic [7:0] IWDIT_IDX_TMR_MAX = 8'h8E;

  // Timer numbering
  localparam int IWDIT_NUM_TMR  = 5;
  localparam int IWDIT_TMR_SER  = 0;
  localparam int IWDIT_TMR_FDD  = 1;
  localparam int IWDIT_TMR_HDD  = 2;
  localparam int IWDIT_TMR_WIN1 = 3;
  localparam int IWDIT_TMR_WIN2 = 4;

  // Timer register fields
  localparam int IWDIT_TB_ENABLE = 7;
  localparam int IWDIT_TB_STATUS = 6;
  localparam int IWDIT_TB_FINE   = 5;
  localparam int IWDIT_TB_EXCL   = 4;
  localparam int IWDIT_CNT_W     = 4;
  localparam logic [3:0] IWDIT_CNT_RESET = 4'hF;

  // Window size codes in the low base register
  localparam logic [1:0] IWDIT_SIZE_4  = 2'h0;
  localparam logic [1:0] IWDIT_SIZE_8  = 2'h1;
  localparam logic [1:0] IWDIT_SIZE_16 = 2'h2;
  localparam logic [1:0] IWDIT_SIZE_32 = 2'h3;

  // Fixed peripheral ranges
  localparam logic [15:0] IWDIT_COM1_LO = 16'h03F8;
  localparam logic [15:0] IWDIT_COM1_HI = 16'h03FF;
  localparam logic [15:0] IWDIT_COM2_LO = 16'h02F8;
  localparam logic [15:0] IWDIT_COM2_HI = 16'h02FF;
  localparam logic [15:0] IWDIT_LPT1_LO = 16'h0378;
  localparam logic [15:0] IWDIT_LPT1_HI = 16'h037A;
  localparam logic [15:0] IWDIT_FDD_LO  = 16'h03F0;
  localparam logic [15:0] IWDIT_FDD_HI  = 16'h03F5;
  localparam logic [15:0] IWDIT_HDD_LO  = 16'h01F0;
  localparam logic [15:0] IWDIT_HDD_HI  = 16'h01F7;
  localparam logic [15:0] IWDIT_HDD_AUX = 16'h03F6;

  // Step timing from the 32 kHz oscillator
  localparam int IWDIT_RTC_HZ      = 32768;
  localparam int IWDIT_FINE_STEP_S = 4;
  localparam int IWDIT_CRS_STEP_S  = 64;
  localparam int IWDIT_FINE_TICKS  = IWDIT_FINE_STEP_S * IWDIT_RTC_HZ;
  localparam int IWDIT_CRS_TICKS   = IWDIT_CRS_STEP_S * IWDIT_RTC_HZ;
  localparam int IWDIT_DIV_W       = 22;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } iwdit_io_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } iwdit_tmr_acc_t;

endpackage

// ---- src/iwdit_top.sv ----
// I/O window decode and five inactivity timers behind the index/data port
//
// Behaviour
// - Low base bits 7:2 give address 7:2
// - Size code picks 4, 8, 16, 32 bytes
// - High bits 7:2 give 15:10, ten-bit ignores
// - High bits 1:0 give address 9:8
// - Five timers, four-bit max count loaded
// - Resolution bit picks fine or coarse step
// - Counters stepped from the 32 kHz oscillator
// - Setting enable loads count and starts
// - Access in range reloads and restarts count
// - Terminal count: interrupt, status set, enable cleared
// - Reading timer register clears its status
// - Max count kept; live count not readable
// - Serial timer retriggers on two serials, printer
// - Exclusion bit drops second serial retrigger
// - Other timers retrigger on own range only
module iwdit_top
  import iwdit_pkg::*;
#(
  parameter logic [15:0] INDEX_PORT  = IWDIT_INDEX_PORT_DEF, // Configuration index port
  parameter int          FINE_TICKS  = IWDIT_FINE_TICKS,     // Oscillator ticks per fine step
  parameter int          COARSE_TICKS = IWDIT_CRS_TICKS      // Oscillator ticks per coarse step
)(
  input  wire logic                     clk,          // System clock, 40 MHz
  input  wire logic                     rstn,         // Synchronous reset, active low
  input  wire iwdit_io_t                io,           // I/O cycle, one-cycle strobes
  input  wire logic                     rtc_osc,      // 32 kHz oscillator pin
  input  wire logic                     ten_bit_decode_select, // Ten-bit decode select
  output logic [7:0]                    io_rdata,     // Read data of the port
  output logic                          io_rvalid,    // Read data valid pulse
  output logic                          system_mgmt_interrupt_n, // Interrupt, active low
  output logic [IWDIT_NUM_TMR-1:0]      timeout_status, // Sticky timeout flags
  output logic [IWDIT_NUM_TMR-1:0]      timer_enabled   // Timers counting
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (FINE_TICKS < 1 || COARSE_TICKS < 1 ||
      FINE_TICKS >= (1 << IWDIT_DIV_W) || COARSE_TICKS >= (1 << IWDIT_DIV_W)) begin : g_chk
    $error("iwdit_top: step tick counts out of range");
  end

  localparam logic [IWDIT_DIV_W-1:0] FINE_LAST = IWDIT_DIV_W'(FINE_TICKS - 1);
  localparam logic [IWDIT_DIV_W-1:0] CRS_LAST  = IWDIT_DIV_W'(COARSE_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser and step dividers
  logic                   osc_s1, osc_s2, osc_s3;
  logic [IWDIT_DIV_W-1:0] fine_div, next_fine_div;
  logic [IWDIT_DIV_W-1:0] crs_div, next_crs_div;
  logic                   step_fine, next_step_fine;
  logic                   step_crs, next_step_crs;
  logic                   osc_tick;

  // Rising edge of the synchronised oscillator
  always_comb begin
    osc_tick       = osc_s2 & ~osc_s3;
    next_fine_div  = fine_div;
    next_crs_div   = crs_div;
    next_step_fine = 1'b0;
    next_step_crs  = 1'b0;
    if (osc_tick) begin
      if (fine_div == FINE_LAST) begin
        next_fine_div  = '0;
        next_step_fine = 1'b1;
      end else begin
        next_fine_div = fine_div + 1'b1;
      end
      if (crs_div == CRS_LAST) begin
        next_crs_div  = '0;
        next_step_crs = 1'b1;
      end else begin
        next_crs_div = crs_div + 1'b1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_s1    <= 1'b0;
      osc_s2    <= 1'b0;
      osc_s3    <= 1'b0;
      fine_div  <= '0;
      crs_div   <= '0;
      step_fine <= 1'b0;
      step_crs  <= 1'b0;
    end else begin
      osc_s1    <= rtc_osc;
      osc_s2    <= osc_s1;
      osc_s3    <= osc_s2;
      fine_div  <= next_fine_div;
      crs_div   <= next_crs_div;
      step_fine <= next_step_fine;
      step_crs  <= next_step_crs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index and data port
  logic [7:0] cfg_index, next_cfg_index;
  logic [7:0] win1_hi, next_win1_hi;
  logic [7:0] win1_lo, next_win1_lo;
  logic [7:0] win2_hi, next_win2_hi;
  logic [7:0] win2_lo, next_win2_lo;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       idx_sel, dat_sel, tmr_idx;
  logic [2:0] tmr_num;

  iwdit_tmr_acc_t [IWDIT_NUM_TMR-1:0] tmr_acc;
  logic [IWDIT_NUM_TMR-1:0][7:0]       tmr_reg;
  logic [IWDIT_NUM_TMR-1:0]            tmr_excl;
  logic [IWDIT_NUM_TMR-1:0]            retrig;

  // Port decode, register writes and read mux
  always_comb begin
    idx_sel        = io.addr == INDEX_PORT;
    dat_sel        = io.addr == IWDIT_DATA_PORT;
    tmr_idx        = cfg_index >= IWDIT_IDX_TMR0 && cfg_index <= IWDIT_IDX_TMR_MAX;
    tmr_num        = 3'(cfg_index - IWDIT_IDX_TMR0);
    next_cfg_index = cfg_index;
    next_win1_hi   = win1_hi;
    next_win1_lo   = win1_lo;
    next_win2_hi   = win2_hi;
    next_win2_lo   = win2_lo;
    next_rdata     = io_rdata;
    next_rvalid    = 1'b0;
    if (io.wr && idx_sel) begin
      next_cfg_index = io.wdata;
    end else if (io.wr && dat_sel) begin
      if (cfg_index == IWDIT_IDX_WIN2_HI) begin
        next_win2_hi = io.wdata;
      end else if (cfg_index == IWDIT_IDX_WIN2_LO) begin
        next_win2_lo = io.wdata;
      end else if (cfg_index == IWDIT_IDX_WIN1_HI) begin
        next_win1_hi = io.wdata;
      end else if (cfg_index == IWDIT_IDX_WIN1_LO) begin
        next_win1_lo = io.wdata;
      end
    end
    if (io.rd && (idx_sel || dat_sel)) begin
      next_rvalid = 1'b1;
      if (idx_sel) begin
        next_rdata = cfg_index;
      end else if (cfg_index == IWDIT_IDX_WIN2_HI) begin
        next_rdata = win2_hi;
      end else if (cfg_index == IWDIT_IDX_WIN2_LO) begin
        next_rdata = win2_lo;
      end else if (cfg_index == IWDIT_IDX_WIN1_HI) begin
        next_rdata = win1_hi;
      end else if (cfg_index == IWDIT_IDX_WIN1_LO) begin
        next_rdata = win1_lo;
      end else if (tmr_idx) begin
        next_rdata = tmr_reg[tmr_num];
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // Port registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_index <= 8'h00;
      win1_hi   <= 8'h00;
      win1_lo   <= 8'h00;
      win2_hi   <= 8'h00;
      win2_lo   <= 8'h00;
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      cfg_index <= next_cfg_index;
      win1_hi   <= next_win1_hi;
      win1_lo   <= next_win1_lo;
      win2_hi   <= next_win2_hi;
      win2_lo   <= next_win2_lo;
      io_rdata  <= next_rdata;
      io_rvalid <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral range decode
  logic        win1_hit, win2_hit;
  logic [15:0] dec_addr;
  logic        hit_com1, hit_com2, hit_lpt1, hit_fdd, hit_hdd;
  logic        io_cyc;

  iwdit_window_match u_win1 (
    .base_hi (win1_hi),
    .base_lo (win1_lo),
    .ten_bit (ten_bit_decode_select),
    .addr    (io.addr),
    .hit     (win1_hit)
  );

  iwdit_window_match u_win2 (
    .base_hi (win2_hi),
    .base_lo (win2_lo),
    .ten_bit (ten_bit_decode_select),
    .addr    (io.addr),
    .hit     (win2_hit)
  );

  // Fixed ranges and retrigger sources
  always_comb begin
    io_cyc   = io.rd | io.wr;
    dec_addr = ten_bit_decode_select ? {6'h00, io.addr[9:0]} : io.addr;
    hit_com1 = dec_addr >= IWDIT_COM1_LO && dec_addr <= IWDIT_COM1_HI;
    hit_com2 = dec_addr >= IWDIT_COM2_LO && dec_addr <= IWDIT_COM2_HI;
    hit_lpt1 = dec_addr >= IWDIT_LPT1_LO && dec_addr <= IWDIT_LPT1_HI;
    hit_fdd  = dec_addr >= IWDIT_FDD_LO && dec_addr <= IWDIT_FDD_HI;
    hit_hdd  = (dec_addr >= IWDIT_HDD_LO && dec_addr <= IWDIT_HDD_HI) ||
               dec_addr == IWDIT_HDD_AUX;
    retrig                 = '0;
    retrig[IWDIT_TMR_SER]  = io_cyc & (hit_com1 | hit_lpt1 |
                             (hit_com2 & ~tmr_excl[IWDIT_TMR_SER]));
    retrig[IWDIT_TMR_FDD]  = io_cyc & hit_fdd;
    retrig[IWDIT_TMR_HDD]  = io_cyc & hit_hdd;
    retrig[IWDIT_TMR_WIN1] = io_cyc & win1_hit;
    retrig[IWDIT_TMR_WIN2] = io_cyc & win2_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Five inactivity timers
  for (genvar t = 0; t < IWDIT_NUM_TMR; t++) begin : g_tmr
    localparam logic [7:0] MY_IDX = IWDIT_IDX_TMR0 + 8'(t);

    // Per-timer register strobes
    assign tmr_acc[t].wr   = io.wr & dat_sel & (cfg_index == MY_IDX);
    assign tmr_acc[t].rd   = io.rd & dat_sel & (cfg_index == MY_IDX);
    assign tmr_acc[t].data = io.wdata;

    iwdit_idle_timer #(
      .HAS_EXCL (t == IWDIT_TMR_SER)
    ) u_tmr (
      .clk         (clk),
      .rstn        (rstn),
      .acc         (tmr_acc[t]),
      .retrig      (retrig[t]),
      .step_fine   (step_fine),
      .step_coarse (step_crs),
      .reg_value   (tmr_reg[t]),
      .excl        (tmr_excl[t]),
      .timeout     ()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs and interrupt
  logic [IWDIT_NUM_TMR-1:0] next_status_vec, next_enabled_vec;
  logic                     next_smi_n;

  // Gather status and enable bits
  always_comb begin
    for (int i = 0; i < IWDIT_NUM_TMR; i++) begin
      next_status_vec[i]  = tmr_reg[i][IWDIT_TB_STATUS];
      next_enabled_vec[i] = tmr_reg[i][IWDIT_TB_ENABLE];
    end
    next_smi_n = ~(|next_status_vec);
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timeout_status          <= '0;
      timer_enabled           <= '0;
      system_mgmt_interrupt_n <= 1'b1;
    end else begin
      timeout_status          <= next_status_vec;
      timer_enabled           <= next_enabled_vec;
      system_mgmt_interrupt_n <= next_smi_n;
    end
  end

endmodule

// ---- src/iwdit_window_match.sv ----
// Programmable I/O window compare against a base and size code
module iwdit_window_match
  import iwdit_pkg::*;
(
  input  wire logic [7:0]  base_hi,   // Base bits 15:8
  input  wire logic [7:0]  base_lo,   // Base bits 7:2 and size code
  input  wire logic        ten_bit,   // Ten-bit decode select
  input  wire logic [15:0] addr,      // I/O address of the cycle
  output logic             hit        // Address falls in the window
);

  logic [15:0] care;
  logic [15:0] base;
  logic [1:0]  size;

  // Base bits and don't-care mask
  always_comb begin
    size     = base_lo[1:0];
    base     = {base_hi[7:2], base_hi[1:0], base_lo[7:2], 2'h0};
    care     = 16'hFFFC;
    if (ten_bit) begin
      care[15:10] = 6'h00;
    end
    if (size == IWDIT_SIZE_32) begin
      care[4] = 1'b0;
    end
    if (size == IWDIT_SIZE_16 || size == IWDIT_SIZE_32) begin
      care[3] = 1'b0;
    end
    if (size != IWDIT_SIZE_4) begin
      care[2] = 1'b0;
    end
    hit = ((addr ^ base) & care) == 16'h0000;
  end

endmodule
